/* File: verif/pmc_osc_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Fast oscillator: stable only after enable holds for STABLE_CYC
// ----------------------------------------------------------------
module pmc_osc_model #(
  parameter int STABLE_CYC = 4
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  input  wire logic i_fast_osc_en,
  output logic      o_fast_osc_stable
);
  int stable_cnt_reg;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stable_cnt_reg <= 0;
    end else if (!i_fast_osc_en) begin
      stable_cnt_reg <= 0;
    end else if (stable_cnt_reg < STABLE_CYC) begin
      stable_cnt_reg <= stable_cnt_reg + 1;
    end
  end

  // Drops at once when the oscillator is switched off
  assign o_fast_osc_stable = i_fast_osc_en && (stable_cnt_reg == STABLE_CYC);
endmodule : pmc_osc_model

/* File: verif/test_power_mode_controller.sv */
`timescale 1ns/1ps

module test_power_mode_controller;
  logic       clk = 1'b0, rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, o_rdata;
  logic       wr = 1'b0, rd = 1'b0, wait_x = 1'b0, wake = 1'b0;
  logic       nmi = 1'b0, ack = 1'b0, main_good = 1'b1;
  logic       slow_good = 1'b1, xtal = 1'b1, stable;
  logic       stall, osc_en, fclk, sclk, tclk, pend;
  logic [2:0] mode;
  int         fail_count = 0, checks_done = 0;

  always #2.5 clk = ~clk;

  pmc_power_mode_controller i_dut (.i_ref_clk(clk), .i_rstn(rstn),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(o_rdata), .i_wait_exec(wait_x), .i_wake_unit(wake),
    .i_nmi(nmi), .i_int_ack(ack), .i_fast_osc_stable(stable),
    .i_main_clk_good(main_good), .i_slow_osc_good(slow_good),
    .i_slow_src_crystal(xtal), .o_cpu_stall(stall),
    .o_fast_osc_en(osc_en), .o_mod_fast_clk_en(fclk),
    .o_mod_slow_clk_en(sclk), .o_pmm_twm_clk_en(tclk),
    .o_wake_pending(pend), .o_mode(mode));

  pmc_osc_model i_osc (.i_ref_clk(clk), .i_rstn(rstn),
    .i_fast_osc_en(osc_en), .o_fast_osc_stable(stable));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check("read data", o_rdata, exp);
  endtask : rd_reg

  task automatic pulse(input int which);
    @(posedge clk);
    case (which)
      0: wait_x <= 1'b1;
      1: wake <= 1'b1;
      2: nmi <= 1'b1;
      default: ack <= 1'b1;
    endcase
    @(posedge clk);
    {wait_x, wake, nmi, ack} <= 4'h0;
  endtask : pulse

  task automatic wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    #1;
    while (mode !== m) begin
      @(posedge clk);
      #1 n++;
      if (n > 50) begin
        check("mode", {5'h00, mode}, {5'h00, m});
        report_and_stop();
      end
    end
    checks_done++;
  endtask : wait_mode

  function automatic logic [7:0] clocks();
    return {4'h0, osc_en, fclk, sclk, tclk};
  endfunction : clocks

  // Wait into a low mode, check clocks, wake, acknowledge
  task automatic sleep_wake(input logic [7:0] d, input logic [2:0] m,
                            input logic [3:0] ce, input int src);
    wr_reg(4'h0, d);
    pulse(0);
    wait_mode(m);
    check("clocks", clocks(), {4'h0, ce});
    check("stall", {7'h00, stall}, 8'h01);
    pulse(src);
    #1 check("pending", {7'h00, pend}, 8'h01);
    wait_mode(pmc_pkg::PMC_ACTIVE);
    rd_reg(4'h0, 8'he0);
    check("stall held", {7'h00, stall}, 8'h01);
    pulse(3);
    #1 check("ack", {6'h00, pend, stall}, 8'h00);
  endtask : sleep_wake

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    #1 check("mode", {5'h00, mode}, 8'h00);
    check("clocks", clocks(), 8'h0d);
    rd_reg(4'h0, 8'hc0);
    rd_reg(4'hf, 8'h00);
    $display("test reset done");
    pulse(1);
    #1 check("pending", {7'h00, pend}, 8'h01);
    check("mode", {5'h00, mode}, 8'h00);
    pulse(3);
    wr_reg(4'h0, 8'h3f);
    wr_reg(4'h1, 8'hff);
    rd_reg(4'h0, 8'hef);
    check("mode", {5'h00, mode}, 8'h00);
    wr_reg(4'h0, 8'h00);
    rd_reg(4'h0, 8'hc0);
    $display("test register done");
    wr_reg(4'h0, 8'h01);
    wait_mode(pmc_pkg::PMC_PSAVE);
    rd_reg(4'h0, 8'hc1);
    check("clocks", clocks(), 8'h0b);
    check("stall", {7'h00, stall}, 8'h00);
    wr_reg(4'h0, 8'h03);
    rd_reg(4'h0, 8'h83);
    wr_reg(4'h0, 8'h00);
    wait_mode(pmc_pkg::PMC_ACTIVE);
    rd_reg(4'h0, 8'hc0);
    $display("test immediate power save done");
    sleep_wake(8'h21, pmc_pkg::PMC_PSAVE, 4'hb, 2);
    sleep_wake(8'h26, pmc_pkg::PMC_IDLE, 4'h1, 1);
    sleep_wake(8'h2c, pmc_pkg::PMC_HALT, 4'h0, 2);
    $display("test wait modes done");
    xtal <= 1'b0;
    wr_reg(4'h0, 8'h03);
    wait_mode(pmc_pkg::PMC_PSAVE);
    check("fast osc", {7'h00, osc_en}, 8'h01);
    wr_reg(4'h0, 8'h00);
    wait_mode(pmc_pkg::PMC_ACTIVE);
    xtal <= 1'b1;
    $display("test divided slow clock done");
    main_good <= 1'b0;
    slow_good <= 1'b0;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    rd_reg(4'h0, 8'h40);
    wr_reg(4'h0, 8'h01);
    repeat (8) @(posedge clk);
    #1 check("mode", {5'h00, mode}, 8'h00);
    wr_reg(4'h0, 8'h2c);
    pulse(0);
    wait_mode(pmc_pkg::PMC_HALT);
    pulse(2);
    wait_mode(pmc_pkg::PMC_ACTIVE);
    $display("test slow clock not good done");
    report_and_stop();
  end
endmodule : test_power_mode_controller

/* File: verilog/pmc_pkg.sv */
package pmc_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [3:0] PMC_ADDR_CTRL_STATUS = 4'h0;
  localparam logic [3:0] PMC_ADDR_STATE       = 4'h1;
  localparam logic [7:0] PMC_CTRL_RESET       = 8'h00;

  // ------------------------------------------------------------------
  // Control/status field positions
  // ------------------------------------------------------------------
  localparam int PMC_BIT_PSAVE   = 0;
  localparam int PMC_BIT_FOSC_D  = 1;
  localparam int PMC_BIT_IDLE    = 2;
  localparam int PMC_BIT_HALT    = 3;
  localparam int PMC_BIT_WAITPS  = 5;
  localparam int PMC_BIT_FGOOD   = 6;
  localparam int PMC_BIT_SGOOD   = 7;

  // ------------------------------------------------------------------
  // Modes
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    PMC_ACTIVE  = 3'b000,
    PMC_PSAVE   = 3'b001,
    PMC_IDLE    = 3'b010,
    PMC_HALT    = 3'b011,
    PMC_WAKE    = 3'b100
  } pmc_mode_t;

endpackage : pmc_pkg

/* File: verilog/pmc_power_mode_controller.sv */
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps

module pmc_power_mode_controller (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_wait_exec,
  input  wire logic       i_wake_unit,
  input  wire logic       i_nmi,
  input  wire logic       i_int_ack,
  input  wire logic       i_fast_osc_stable,
  input  wire logic       i_main_clk_good,
  input  wire logic       i_slow_osc_good,
  input  wire logic       i_slow_src_crystal,
  output logic            o_cpu_stall,
  output logic            o_fast_osc_en,
  output logic            o_mod_fast_clk_en,
  output logic            o_mod_slow_clk_en,
  output logic            o_pmm_twm_clk_en,
  output logic            o_wake_pending,
  output logic      [2:0] o_mode
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  pmc_pkg::pmc_mode_t mode_reg, mode_next;
  logic       psave_reg,  psave_next;
  logic       foscd_reg,  foscd_next;
  logic       idle_reg,   idle_next;
  logic       halt_reg,   halt_next;
  logic       waitps_reg, waitps_next;
  logic       pend_reg,   pend_next;
  logic       stall_reg,  stall_next;
  logic       sgood_reg,  sgood_next;
  logic       mgood_reg,  mgood_next;
  logic       sogood_reg, sogood_next;
  logic       cap_reg,    cap_next;
  logic [7:0] rdata_reg,  rdata_next;
  logic       fgood;
  logic       wake_evt;
  logic       wr_cs;
  logic [7:0] cs_view;

  assign wr_cs    = i_wr && (i_addr == pmc_pkg::PMC_ADDR_CTRL_STATUS);
  assign wake_evt = i_wake_unit || i_nmi;
  assign fgood    = i_fast_osc_stable && o_fast_osc_en;

  // ------------------------------------------------------------------
  // Clock-good indicators
  // ------------------------------------------------------------------
  always_comb begin
    cap_next    = 1'b1;
    mgood_next  = mgood_reg;
    sogood_next = sogood_reg;
    if (!cap_reg) begin
      mgood_next  = i_main_clk_good;
      sogood_next = i_slow_osc_good;
    end
    sgood_next = i_slow_src_crystal ? sogood_reg : mgood_reg;
  end

  // ------------------------------------------------------------------
  // Mode sequencing and register bits
  // ------------------------------------------------------------------
  always_comb begin
    mode_next   = mode_reg;
    psave_next  = psave_reg;
    foscd_next  = foscd_reg;
    idle_next   = idle_reg;
    halt_next   = halt_reg;
    waitps_next = waitps_reg;
    stall_next  = stall_reg;
    pend_next   = pend_reg;
    // Latch held until acknowledge; event wins over ack
    if (i_int_ack) begin
      pend_next  = 1'b0;
      stall_next = 1'b0;
    end
    if (wake_evt) begin
      pend_next = 1'b1;
    end
    if (wr_cs) begin
      foscd_next  = i_wdata[pmc_pkg::PMC_BIT_FOSC_D];
      idle_next   = i_wdata[pmc_pkg::PMC_BIT_IDLE];
      halt_next   = i_wdata[pmc_pkg::PMC_BIT_HALT];
      waitps_next = i_wdata[pmc_pkg::PMC_BIT_WAITPS];
      if (mode_reg == pmc_pkg::PMC_ACTIVE && i_wdata[pmc_pkg::PMC_BIT_PSAVE]
          && i_wdata[pmc_pkg::PMC_BIT_WAITPS]) begin
        psave_next = 1'b1;
      end
      if (mode_reg == pmc_pkg::PMC_ACTIVE
          && !i_wdata[pmc_pkg::PMC_BIT_PSAVE]) begin
        psave_next = 1'b0;
      end
    end
    case (mode_reg)
      pmc_pkg::PMC_ACTIVE: begin
        if (i_wait_exec) begin
          stall_next = 1'b1;
          if (halt_reg) begin
            mode_next = pmc_pkg::PMC_HALT;
          end else if (idle_reg && waitps_reg && sgood_reg) begin
            mode_next = pmc_pkg::PMC_IDLE;
          end else if (psave_reg && waitps_reg && sgood_reg) begin
            mode_next = pmc_pkg::PMC_PSAVE;
          end
        end else if (wr_cs && i_wdata[pmc_pkg::PMC_BIT_PSAVE]
                     && !i_wdata[pmc_pkg::PMC_BIT_WAITPS]) begin
          psave_next = 1'b0;
          mode_next  = pmc_pkg::PMC_WAKE;
          if (sgood_reg) begin
            mode_next  = pmc_pkg::PMC_PSAVE;
            psave_next = 1'b1;
          end
        end else if (psave_reg && !waitps_reg && sgood_reg) begin
          mode_next  = pmc_pkg::PMC_PSAVE;
        end
      end
      pmc_pkg::PMC_PSAVE: begin
        if (wake_evt) begin
          mode_next = pmc_pkg::PMC_WAKE;
        end else if (i_wait_exec) begin
          stall_next = 1'b1;
          if (halt_reg) begin
            mode_next = pmc_pkg::PMC_HALT;
          end else if (idle_reg) begin
            mode_next = pmc_pkg::PMC_IDLE;
          end
        end else if (wr_cs && !i_wdata[pmc_pkg::PMC_BIT_PSAVE]) begin
          foscd_next = 1'b0;
          mode_next  = pmc_pkg::PMC_WAKE;
        end
      end
      pmc_pkg::PMC_IDLE, pmc_pkg::PMC_HALT: begin
        if (wake_evt) begin
          mode_next = pmc_pkg::PMC_WAKE;
        end
      end
      default: begin
        // Returning: fast clock must be good before active
        foscd_next = 1'b0;
        if (fgood) begin
          mode_next  = pmc_pkg::PMC_ACTIVE;
          psave_next = 1'b0;
        end
      end
    endcase
    if (wake_evt && mode_reg != pmc_pkg::PMC_ACTIVE) begin
      psave_next = 1'b0;
      foscd_next = 1'b0;
      idle_next  = 1'b0;
      halt_next  = 1'b0;
      if (mode_reg != pmc_pkg::PMC_WAKE) begin
        mode_next = pmc_pkg::PMC_WAKE;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------------
  always_comb begin
    cs_view = pmc_pkg::PMC_CTRL_RESET;
    cs_view[pmc_pkg::PMC_BIT_PSAVE]  = psave_reg;
    cs_view[pmc_pkg::PMC_BIT_FOSC_D] = foscd_reg;
    cs_view[pmc_pkg::PMC_BIT_IDLE]   = idle_reg;
    cs_view[pmc_pkg::PMC_BIT_HALT]   = halt_reg;
    cs_view[pmc_pkg::PMC_BIT_WAITPS] = waitps_reg;
    cs_view[pmc_pkg::PMC_BIT_FGOOD]  = fgood;
    cs_view[pmc_pkg::PMC_BIT_SGOOD]  = sgood_reg;
    rdata_next = 8'h00;
    if (i_rd && i_addr == pmc_pkg::PMC_ADDR_CTRL_STATUS) begin
      rdata_next = cs_view;
    end else if (i_rd && i_addr == pmc_pkg::PMC_ADDR_STATE) begin
      rdata_next = {4'h0, pend_reg, mode_reg};
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_reg   <= pmc_pkg::PMC_ACTIVE;
      psave_reg  <= 1'b0;
      foscd_reg  <= 1'b0;
      idle_reg   <= 1'b0;
      halt_reg   <= 1'b0;
      waitps_reg <= 1'b0;
      pend_reg   <= 1'b0;
      stall_reg  <= 1'b0;
      sgood_reg  <= 1'b0;
      mgood_reg  <= 1'b0;
      sogood_reg <= 1'b0;
      cap_reg    <= 1'b0;
      rdata_reg  <= 8'h00;
    end else begin
      mode_reg   <= mode_next;
      psave_reg  <= psave_next;
      foscd_reg  <= foscd_next;
      idle_reg   <= idle_next;
      halt_reg   <= halt_next;
      waitps_reg <= waitps_next;
      pend_reg   <= pend_next;
      stall_reg  <= stall_next;
      sgood_reg  <= sgood_next;
      mgood_reg  <= mgood_next;
      sogood_reg <= sogood_next;
      cap_reg    <= cap_next;
      rdata_reg  <= rdata_next;
    end
  end

  // ------------------------------------------------------------------
  // Clock gating outputs
  // ------------------------------------------------------------------
  always_comb begin
    o_fast_osc_en = 1'b1;
    if (mode_reg == pmc_pkg::PMC_HALT) begin
      o_fast_osc_en = 1'b0;
    end else if ((mode_reg == pmc_pkg::PMC_PSAVE
                  || mode_reg == pmc_pkg::PMC_IDLE)
                 && foscd_reg && i_slow_src_crystal) begin
      o_fast_osc_en = 1'b0;
    end
  end

  assign o_mod_fast_clk_en = (mode_reg == pmc_pkg::PMC_ACTIVE);
  assign o_mod_slow_clk_en = (mode_reg == pmc_pkg::PMC_PSAVE);
  assign o_pmm_twm_clk_en  = (mode_reg != pmc_pkg::PMC_HALT);
  assign o_cpu_stall       = stall_reg;
  assign o_wake_pending    = pend_reg;
  assign o_mode            = mode_reg;
  assign o_rdata           = rdata_reg;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking chk_cb @(posedge i_ref_clk);
  endclocking

  default disable iff (!i_rstn);

  // ------------------------------------------------------------------
  // Wake latch and stall
  // ------------------------------------------------------------------
  wake_latch_a: assert property (
    wake_evt
    |=> o_wake_pending)
    else $error("wake not latched");

  pend_hold_a: assert property (
    o_wake_pending && !i_int_ack
    |=> o_wake_pending)
    else $error("wake pending lost");

  ack_clear_a: assert property (
    i_int_ack && !wake_evt && !i_wait_exec
    |=> !o_wake_pending && !o_cpu_stall)
    else $error("ack did not clear");

  wait_stall_a: assert property (
    mode_reg == pmc_pkg::PMC_ACTIVE && i_wait_exec
    |=> o_cpu_stall)
    else $error("wait did not stall");

  wake_stall_a: assert property (
    mode_reg == pmc_pkg::PMC_WAKE && fgood && !i_int_ack
    |=> mode_reg == pmc_pkg::PMC_ACTIVE && o_cpu_stall == $past(o_cpu_stall))
    else $error("return changed execution");

  // ------------------------------------------------------------------
  // Clocking per mode
  // ------------------------------------------------------------------
  halt_osc_a: assert property (
    mode_reg == pmc_pkg::PMC_HALT
    |-> !o_fast_osc_en && !fgood)
    else $error("osc on in halt");

  halt_clock_a: assert property (
    mode_reg == pmc_pkg::PMC_HALT
    |-> !o_mod_fast_clk_en && !o_mod_slow_clk_en && !o_pmm_twm_clk_en)
    else $error("clock running in halt");

  idle_clock_a: assert property (
    mode_reg == pmc_pkg::PMC_IDLE
    |-> !o_mod_fast_clk_en && !o_mod_slow_clk_en && o_pmm_twm_clk_en)
    else $error("idle clocking wrong");

  psave_clock_a: assert property (
    mode_reg == pmc_pkg::PMC_PSAVE
    |-> o_mod_slow_clk_en && !o_mod_fast_clk_en && o_pmm_twm_clk_en)
    else $error("power save clocking wrong");

  active_clk_a: assert property (
    mode_reg == pmc_pkg::PMC_ACTIVE
    |-> o_fast_osc_en && o_mod_fast_clk_en)
    else $error("active clocking wrong");

  no_xtal_osc_a: assert property (
    !i_slow_src_crystal && mode_reg != pmc_pkg::PMC_HALT
    |-> o_fast_osc_en)
    else $error("osc off without crystal");

  // ------------------------------------------------------------------
  // Mode transitions
  // ------------------------------------------------------------------
  active_fgood_a: assert property (
    mode_reg == pmc_pkg::PMC_WAKE && !fgood
    |=> mode_reg != pmc_pkg::PMC_ACTIVE)
    else $error("active without fast clock");

  halt_prio_a: assert property (
    mode_reg == pmc_pkg::PMC_ACTIVE && i_wait_exec && halt_reg && !wake_evt
    |=> mode_reg == pmc_pkg::PMC_HALT)
    else $error("halt not taken");

  wake_clear_a: assert property (
    wake_evt && mode_reg != pmc_pkg::PMC_ACTIVE
    |=> !psave_reg && !idle_reg && !halt_reg && !foscd_reg)
    else $error("bits not cleared on wake");

  wake_return_a: assert property (
    wake_evt && mode_reg inside {pmc_pkg::PMC_PSAVE, pmc_pkg::PMC_IDLE,
                                 pmc_pkg::PMC_HALT}
    |=> mode_reg == pmc_pkg::PMC_WAKE)
    else $error("wake did not start return");

  wake_osc_a: assert property (
    mode_reg == pmc_pkg::PMC_WAKE
    |=> !foscd_reg)
    else $error("osc disable kept on return");

  sgood_gate_a: assert property (
    mode_reg == pmc_pkg::PMC_ACTIVE && !sgood_reg
    |=> mode_reg != pmc_pkg::PMC_IDLE && mode_reg != pmc_pkg::PMC_PSAVE)
    else $error("low mode without slow clock");

  sgood_sel_a: assert property (
    cap_reg
    |=> sgood_reg == $past(i_slow_src_crystal ? sogood_reg : mgood_reg))
    else $error("slow good selection wrong");

  idle_wait_a: assert property (
    mode_reg == pmc_pkg::PMC_ACTIVE && !waitps_reg
    |=> mode_reg != pmc_pkg::PMC_IDLE)
    else $error("idle without wait bit");

  idle_entry_a: assert property (
    mode_reg == pmc_pkg::PMC_HALT
    |=> mode_reg != pmc_pkg::PMC_IDLE)
    else $error("idle entered from halt");

  wait_ps_a: assert property (
    mode_reg == pmc_pkg::PMC_ACTIVE && wr_cs && !i_wait_exec
    && (i_wdata[pmc_pkg::PMC_BIT_PSAVE] && i_wdata[pmc_pkg::PMC_BIT_WAITPS])
    |=> psave_reg && mode_reg == pmc_pkg::PMC_ACTIVE)
    else $error("deferred power save wrong");

  now_ps_a: assert property (
    mode_reg == pmc_pkg::PMC_ACTIVE && wr_cs && !i_wait_exec && sgood_reg
    && i_wdata[pmc_pkg::PMC_BIT_PSAVE] && !i_wdata[pmc_pkg::PMC_BIT_WAITPS]
    |=> psave_reg && mode_reg == pmc_pkg::PMC_PSAVE)
    else $error("immediate power save wrong");

  ps_exit_a: assert property (
    mode_reg == pmc_pkg::PMC_PSAVE && wr_cs && !wake_evt && !i_wait_exec
    && !i_wdata[pmc_pkg::PMC_BIT_PSAVE]
    |=> psave_reg && mode_reg == pmc_pkg::PMC_WAKE)
    else $error("power save exit wrong");

  // ------------------------------------------------------------------
  // Coverage
  // ------------------------------------------------------------------
  halt_c: cover property (
    mode_reg == pmc_pkg::PMC_HALT ##1 mode_reg == pmc_pkg::PMC_WAKE);
  idle_c: cover property (
    mode_reg == pmc_pkg::PMC_IDLE);
  psave_c: cover property (
    mode_reg == pmc_pkg::PMC_PSAVE ##1 mode_reg == pmc_pkg::PMC_WAKE);
  active_wake_c: cover property (
    mode_reg == pmc_pkg::PMC_ACTIVE && wake_evt);

endmodule : pmc_power_mode_controller
